// [design/ecs_top.sv]
// Our own choices: the placing of the registers and the APB slave port.
module ecs_top #(
   parameter int POLL_CYCLES = ecs_pkg::POLL_CYCLES,
   parameter int MAP_BLOCKS  = ecs_pkg::MAP_BLOCKS,
   parameter int PROBE_LINES = ecs_pkg::PROBE_LINES
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   front_panel_reset_n,
   input  wire logic                   target_reset_n,
   input  wire logic                   target_clk_fast,
   input  wire logic                   keyboard_break,
   input  wire logic                   emulator_break,
   input  wire logic                   sync_line_i,
   output logic                        sync_line_o,
   output logic                        sync_line_oe_n,
   output logic                        run_enable,
   output logic [1:0]                  role,
   output logic                        clk_sel_target,
   output logic                        auto_first_wait_state,
   output logic                        emu_ram_mapped,
   output logic                        expansion_page_b,
   output logic [MAP_BLOCKS-1:0]       expansion_memory_map,
   output logic [PROBE_LINES-1:0]      trace_addr_mask,
   output logic                        poll_keyboard,
   output logic                        poll_emulator
);

   // =====================================================================
   // elaboration checks
   if (PROBE_LINES != 8) begin : g_chk_probe
      $error("probe count must be 8");
   end
   if (MAP_BLOCKS < 1 || MAP_BLOCKS > 32) begin : g_chk_map
      $error("map width must be 1 to 32");
   end
   if (POLL_CYCLES < 2) begin : g_chk_poll
      $error("poll period too short");
   end

   typedef enum {ECS_IDLE, ECS_SYNC_WAIT, ECS_RUNNING} ecs_state_t;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   // =====================================================================
   // pin synchronisers: three stages, change taken when stages 2 and 3 agree
   logic [5:0] pin_raw;
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic [5:0] pin_s3_reg;
   logic [5:0] pin_reg;

   assign pin_raw = {emulator_break, keyboard_break, sync_line_i,
                     target_clk_fast, target_reset_n, front_panel_reset_n};

   for (genvar i = 0; i < 6; i++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_s1_reg[i] <= ecs_pkg::PIN_RST[i];
            pin_s2_reg[i] <= ecs_pkg::PIN_RST[i];
            pin_s3_reg[i] <= ecs_pkg::PIN_RST[i];
            pin_reg[i]    <= ecs_pkg::PIN_RST[i];
         end else begin
            pin_s1_reg[i] <= pin_raw[i];
            pin_s2_reg[i] <= pin_s1_reg[i];
            pin_s3_reg[i] <= pin_s2_reg[i];
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   logic fp_n_f;
   logic tgt_rst_n_f;
   logic tgt_fast_f;
   logic sync_line_f;
   logic kbd_brk_f;
   logic emu_brk_f;
   logic tgt_rst_n_d_reg;

   assign fp_n_f      = pin_reg[0];
   assign tgt_rst_n_f = pin_reg[1];
   assign tgt_fast_f  = pin_reg[2];
   assign sync_line_f = pin_reg[3];
   assign kbd_brk_f   = pin_reg[4];
   assign emu_brk_f   = pin_reg[5];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_rst_n_d_reg <= 1'b1;
      end else begin
         tgt_rst_n_d_reg <= tgt_rst_n_f;
      end
   end

   // =====================================================================
   // apb slave: zero wait states, read data captured in the setup cycle
   logic setup_ph;
   logic wr_acc;
   logic mapped;

   assign setup_ph = psel && !penable;
   assign wr_acc   = psel && penable && pwrite;
   assign mapped   = hit(paddr, ecs_pkg::REG_MODE) || hit(paddr, ecs_pkg::REG_INIT) ||
                     hit(paddr, ecs_pkg::REG_STATUS) || hit(paddr, ecs_pkg::REG_CMD) ||
                     hit(paddr, ecs_pkg::REG_MAP);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;

   // =====================================================================
   // settings
   logic [1:0]            role_reg;
   logic                  sync_en_reg;
   logic                  autopoll_reg;
   logic                  clk_src_reg;
   logic                  emu_ram_reg;
   logic                  page_sel_reg;
   logic [3:0]            abits_reg;
   logic [MAP_BLOCKS-1:0] map_a_reg;
   logic [MAP_BLOCKS-1:0] map_b_reg;
   logic [3:0]            abits_next;

   assign abits_next = pwdata[ecs_pkg::INIT_ABITS_LSB +: 4];

   // front-panel reset held low keeps every setting at its default
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         role_reg     <= ecs_pkg::ROLE_RST;
         sync_en_reg  <= ecs_pkg::SYNC_RST;
         autopoll_reg <= ecs_pkg::POLL_RST;
      end else if (!fp_n_f) begin
         role_reg     <= ecs_pkg::ROLE_RST;
         sync_en_reg  <= ecs_pkg::SYNC_RST;
         autopoll_reg <= ecs_pkg::POLL_RST;
      end else if (wr_acc && hit(paddr, ecs_pkg::REG_MODE)) begin
         // the unused code 3 is refused and the role kept
         if (pwdata[ecs_pkg::MODE_ROLE_LSB +: 2] != 2'h3) begin
            role_reg <= pwdata[ecs_pkg::MODE_ROLE_LSB +: 2];
         end
         sync_en_reg  <= pwdata[ecs_pkg::MODE_SYNC_BIT];
         autopoll_reg <= pwdata[ecs_pkg::MODE_POLL_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_src_reg  <= ecs_pkg::CLK_RST;
         emu_ram_reg  <= ecs_pkg::RAM_RST;
         page_sel_reg <= ecs_pkg::PAGE_RST;
         abits_reg    <= ecs_pkg::ABITS_RST;
      end else if (!fp_n_f) begin
         clk_src_reg  <= ecs_pkg::CLK_INTERNAL;
         emu_ram_reg  <= ecs_pkg::RAM_RST;
         page_sel_reg <= ecs_pkg::PAGE_RST;
         abits_reg    <= ecs_pkg::ABITS_RST;
      end else if (wr_acc && hit(paddr, ecs_pkg::REG_INIT)) begin
         clk_src_reg  <= pwdata[ecs_pkg::INIT_CLK_BIT];
         emu_ram_reg  <= pwdata[ecs_pkg::INIT_RAM_BIT];
         page_sel_reg <= pwdata[ecs_pkg::INIT_PAGE_BIT];
         if (abits_next <= 4'h8) begin
            abits_reg <= abits_next;
         end
      end
   end

   // a map write lands only in the selected page, the other stays put
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_a_reg <= '0;
         map_b_reg <= '0;
      end else if (!fp_n_f) begin
         map_a_reg <= '0;
         map_b_reg <= '0;
      end else if (wr_acc && hit(paddr, ecs_pkg::REG_MAP)) begin
         if (page_sel_reg) begin
            map_b_reg <= pwdata[MAP_BLOCKS-1:0];
         end else begin
            map_a_reg <= pwdata[MAP_BLOCKS-1:0];
         end
      end
   end

   // =====================================================================
   // automatic first wait state
   logic wait_state_reg;

   // an init write arms the wait state from the clock choice it carries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_state_reg <= 1'b0;
      end else if (!fp_n_f) begin
         wait_state_reg <= 1'b0;
      end else if (wr_acc && hit(paddr, ecs_pkg::REG_INIT)) begin
         wait_state_reg <= (pwdata[ecs_pkg::INIT_CLK_BIT] == ecs_pkg::CLK_TARGET);
      end else if (clk_src_reg != ecs_pkg::CLK_TARGET) begin
         wait_state_reg <= 1'b0;
      end else if (tgt_fast_f) begin
         wait_state_reg <= 1'b1;
      end else if (tgt_rst_n_d_reg && !tgt_rst_n_f) begin
         wait_state_reg <= 1'b0;
      end
   end

   // =====================================================================
   // run control with synchronous start over the wired-and chain line
   ecs_state_t state_reg;
   logic       cmd_run;
   logic       cmd_halt;
   logic       brk_reg;

   assign cmd_run  = wr_acc && hit(paddr, ecs_pkg::REG_CMD) && pwdata[ecs_pkg::CMD_RUN_BIT];
   assign cmd_halt = wr_acc && hit(paddr, ecs_pkg::REG_CMD) && pwdata[ecs_pkg::CMD_HALT_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ECS_IDLE;
      end else if (!fp_n_f || cmd_halt || brk_reg) begin
         state_reg <= ECS_IDLE;
      end else begin
         unique case (state_reg)
            ECS_IDLE: begin
               if (cmd_run) begin
                  state_reg <= sync_en_reg ? ECS_SYNC_WAIT : ECS_RUNNING;
               end
            end
            ECS_SYNC_WAIT: begin
               if (!sync_en_reg || sync_line_f) begin
                  state_reg <= ECS_RUNNING;
               end
            end
            ECS_RUNNING: begin
               state_reg <= ECS_RUNNING;
            end
         endcase
      end
   end

   // an armed unit without its run order holds the line low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_line_oe_n <= 1'b1;
      end else begin
         sync_line_oe_n <= !(sync_en_reg && fp_n_f && state_reg == ECS_IDLE && !cmd_run);
      end
   end
   assign sync_line_o = 1'b0;

   // =====================================================================
   // autopoll: divider enable, strobes alternate keyboard then emulator
   logic [$clog2(POLL_CYCLES)-1:0] poll_cnt_reg;
   logic                           poll_tick;
   logic                           poll_phase_reg;

   assign poll_tick = (poll_cnt_reg == '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_cnt_reg <= '0;
      end else if (!autopoll_reg || poll_tick) begin
         poll_cnt_reg <= ($clog2(POLL_CYCLES))'(POLL_CYCLES - 1);
      end else begin
         poll_cnt_reg <= poll_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_phase_reg <= 1'b0;
         poll_keyboard  <= 1'b0;
         poll_emulator  <= 1'b0;
      end else begin
         poll_keyboard <= autopoll_reg && poll_tick && !poll_phase_reg;
         poll_emulator <= autopoll_reg && poll_tick && poll_phase_reg;
         if (!autopoll_reg) begin
            poll_phase_reg <= 1'b0;
         end else if (poll_tick) begin
            poll_phase_reg <= !poll_phase_reg;
         end
      end
   end

   // a break seen on the polled source stops the run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_reg <= 1'b0;
      end else begin
         brk_reg <= (poll_keyboard && kbd_brk_f) || (poll_emulator && emu_brk_f);
      end
   end

   // =====================================================================
   // outputs and read data
   logic [MAP_BLOCKS-1:0] map_cur;

   assign map_cur = page_sel_reg ? map_b_reg : map_a_reg;

   for (genvar i = 0; i < PROBE_LINES; i++) begin : g_probe
      assign trace_addr_mask[i] = (4'(i) < abits_reg);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_enable            <= 1'b0;
         role                  <= ecs_pkg::ROLE_RST;
         clk_sel_target        <= ecs_pkg::CLK_RST;
         auto_first_wait_state <= 1'b0;
         emu_ram_mapped        <= ecs_pkg::RAM_RST;
         expansion_page_b      <= ecs_pkg::PAGE_RST;
         expansion_memory_map  <= '0;
      end else begin
         run_enable            <= (state_reg == ECS_RUNNING);
         role                  <= role_reg;
         clk_sel_target        <= clk_src_reg;
         auto_first_wait_state <= wait_state_reg;
         emu_ram_mapped        <= emu_ram_reg;
         expansion_page_b      <= page_sel_reg;
         expansion_memory_map  <= map_cur;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup_ph && !pwrite) begin
         prdata <= '0;
         if (hit(paddr, ecs_pkg::REG_MODE)) begin
            prdata[3:0] <= {autopoll_reg, sync_en_reg, role_reg};
         end else if (hit(paddr, ecs_pkg::REG_INIT)) begin
            prdata[6:0] <= {abits_reg, page_sel_reg, emu_ram_reg, clk_src_reg};
         end else if (hit(paddr, ecs_pkg::REG_STATUS)) begin
            prdata[5:0] <= {tgt_fast_f, poll_phase_reg, wait_state_reg, sync_line_f,
                            state_reg == ECS_SYNC_WAIT, state_reg == ECS_RUNNING};
         end else if (hit(paddr, ecs_pkg::REG_MAP)) begin
            prdata[MAP_BLOCKS-1:0] <= map_cur;
         end
      end
   end

   // =====================================================================
   // checks
   property p_role_legal;
      @(posedge pclk) disable iff (!presetn)
      role_reg != 2'h3 and (!fp_n_f |=> role_reg == ecs_pkg::ROLE_RST);
   endproperty
   a_role_legal: assert property (p_role_legal) else $error("role illegal or not reset");

   property p_sync_start;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == ECS_SYNC_WAIT && sync_en_reg && fp_n_f && !cmd_halt && !brk_reg && !sync_line_f)
      |=> state_reg == ECS_SYNC_WAIT;
   endproperty
   a_sync_start: assert property (p_sync_start) else $error("started before chain ready");

   property p_sync_drive;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == ECS_RUNNING) |-> ##1 sync_line_oe_n;
   endproperty
   a_sync_drive: assert property (p_sync_drive) else $error("line held while running");

   property p_poll_alt;
      @(posedge pclk) disable iff (!presetn)
      poll_keyboard |-> !poll_emulator ##1 !poll_keyboard [*2];
   endproperty
   a_poll_alt: assert property (p_poll_alt) else $error("poll strobes not alternating");

   property p_poll_off;
      @(posedge pclk) disable iff (!presetn)
      !autopoll_reg [*2] |-> !poll_keyboard && !poll_emulator;
   endproperty
   a_poll_off: assert property (p_poll_off) else $error("poll while autopoll off");

   property p_clk_recover;
      @(posedge pclk) disable iff (!presetn)
      !fp_n_f |-> ##2 !clk_sel_target;
   endproperty
   a_clk_recover: assert property (p_clk_recover) else $error("front panel reset ignored");

   property p_wait_forced;
      @(posedge pclk) disable iff (!presetn)
      (clk_src_reg && tgt_fast_f && fp_n_f && !(wr_acc && hit(paddr, ecs_pkg::REG_INIT)))
      |-> ##2 auto_first_wait_state;
   endproperty
   a_wait_forced: assert property (p_wait_forced) else $error("wait state not forced");

   property p_wait_internal;
      @(posedge pclk) disable iff (!presetn)
      !clk_src_reg |-> !wait_state_reg;
   endproperty
   a_wait_internal: assert property (p_wait_internal) else $error("wait state on internal clock");

   property p_probe_split;
      @(posedge pclk) disable iff (!presetn)
      abits_reg <= 4'h8 && $countones(trace_addr_mask) == int'(abits_reg);
   endproperty
   a_probe_split: assert property (p_probe_split) else $error("probe split wrong");

   property p_page_keep;
      @(posedge pclk) disable iff (!presetn)
      (page_sel_reg && fp_n_f) |=> $stable(map_a_reg);
   endproperty
   a_page_keep: assert property (p_page_keep) else $error("page A map disturbed");

   property p_ram_map;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(paddr, ecs_pkg::REG_INIT) && fp_n_f) |-> ##2 emu_ram_mapped == $past(pwdata[1], 2);
   endproperty
   a_ram_map: assert property (p_ram_map) else $error("ram map setting not applied");

endmodule

// [shared/ecs_pkg.sv]
package ecs_pkg;
   // =====================================================================
   // register map (byte addresses on apb)
   localparam logic [7:0] REG_MODE   = 8'h00;
   localparam logic [7:0] REG_INIT   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CMD    = 8'h0c;
   localparam logic [7:0] REG_MAP    = 8'h10;

   // =====================================================================
   // field positions
   localparam int MODE_ROLE_LSB  = 0;
   localparam int MODE_SYNC_BIT  = 2;
   localparam int MODE_POLL_BIT  = 3;
   localparam int INIT_CLK_BIT   = 0;
   localparam int INIT_RAM_BIT   = 1;
   localparam int INIT_PAGE_BIT  = 2;
   localparam int INIT_ABITS_LSB = 3;
   localparam int CMD_RUN_BIT    = 0;
   localparam int CMD_HALT_BIT   = 1;

   // =====================================================================
   // reset values
   localparam logic [1:0] ROLE_RST  = 2'h0;
   localparam logic       SYNC_RST  = 1'b0;
   localparam logic       POLL_RST  = 1'b0;
   localparam logic       CLK_RST   = 1'b0;
   localparam logic       RAM_RST   = 1'b0;
   localparam logic       PAGE_RST  = 1'b0;
   localparam logic [3:0] ABITS_RST = 4'h0;
   localparam logic [5:0] PIN_RST   = 6'h0b;

   // =====================================================================
   // encodings
   typedef enum logic [1:0] {
      ECS_STANDALONE_ROLE = 2'h0,
      ECS_MASTER_ROLE     = 2'h1,
      ECS_SLAVE_ROLE      = 2'h2
   } ecs_role_t;

   localparam logic CLK_INTERNAL = 1'b0;
   localparam logic CLK_TARGET   = 1'b1;
   localparam int   PROBE_LINES  = 8;
   localparam int   MAP_BLOCKS   = 16;

   // =====================================================================
   // timing
   localparam int CLK_MHZ        = 10;
   localparam int POLL_PERIOD_US = 100;
   localparam int POLL_CYCLES    = POLL_PERIOD_US * CLK_MHZ;
endpackage

// [tb/ecs_partner.sv]
// =====================================================
// target system and peer emulator chain
module ecs_partner (
   input  wire logic pclk,
   input  wire logic sync_line_o,
   input  wire logic sync_line_oe_n,
   output wire logic sync_line_i,
   output logic      target_reset_n,
   output logic      target_clk_fast,
   output logic      keyboard_break,
   output logic      emulator_break
);
   timeunit 1ns;
   timeprecision 1ns;
   logic peer_release = 1'b1;
   initial begin
      target_reset_n = 1'b1;
      target_clk_fast = 1'b0;
      keyboard_break = 1'b0;
      emulator_break = 1'b0;
   end
   // pulled-up wired-and line, a peer without its run order holds it low
   assign sync_line_i = peer_release & (sync_line_oe_n | sync_line_o);
   task set_pins(input logic rel, input logic rst_n, input logic fast, input logic kb, input logic eb);
      @(posedge pclk);
      peer_release <= rel;
      target_reset_n <= rst_n;
      target_clk_fast <= fast;
      keyboard_break <= kb;
      emulator_break <= eb;
   endtask
endmodule

// [tb/test_emulator_config_sync_control.sv]
module test_emulator_config_sync_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        front_panel_reset_n = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] expansion_memory_map;
   logic [7:0]  trace_addr_mask;
   logic [1:0]  role;
   logic        pready, pslverr, er, target_reset_n, target_clk_fast, keyboard_break, emulator_break;
   logic        sync_line_i, sync_line_o, sync_line_oe_n, run_enable, clk_sel_target, auto_first_wait_state;
   logic        emu_ram_mapped, expansion_page_b, poll_keyboard, poll_emulator;
   int          miscompares = 0, tests_run = 0;

   always #50 pclk = ~pclk;

   ecs_top #(.POLL_CYCLES(4)) ecs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .front_panel_reset_n(front_panel_reset_n), .target_reset_n(target_reset_n),
      .target_clk_fast(target_clk_fast), .keyboard_break(keyboard_break), .emulator_break(emulator_break),
      .sync_line_i(sync_line_i), .sync_line_o(sync_line_o), .sync_line_oe_n(sync_line_oe_n),
      .run_enable(run_enable), .role(role), .clk_sel_target(clk_sel_target),
      .auto_first_wait_state(auto_first_wait_state), .emu_ram_mapped(emu_ram_mapped),
      .expansion_page_b(expansion_page_b), .expansion_memory_map(expansion_memory_map),
      .trace_addr_mask(trace_addr_mask), .poll_keyboard(poll_keyboard), .poll_emulator(poll_emulator));

   ecs_partner ecs_partner_inst (.pclk(pclk), .sync_line_o(sync_line_o), .sync_line_oe_n(sync_line_oe_n),
      .sync_line_i(sync_line_i), .target_reset_n(target_reset_n), .target_clk_fast(target_clk_fast),
      .keyboard_break(keyboard_break), .emulator_break(emulator_break));

   // =====================================================
   // shared tasks
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // =====================================================
   // scenarios
   task t_defaults;
      chk(32'(role), 32'h0);
      chk(32'(clk_sel_target), 32'h0);
      chk(32'(emu_ram_mapped), 32'h0);
      chk(32'(trace_addr_mask), 32'h0);
      rdc(ecs_pkg::REG_INIT, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(er), 32'h1);
   endtask
   task t_roles;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ecs_pkg::REG_MODE, 32'(i));
         cyc(1);
         chk(32'(role), (i == 3) ? 32'h2 : 32'(i));
      end
   endtask
   task t_init;
      for (int n = 0; n <= 8; n++) begin
         apb(1'b1, ecs_pkg::REG_INIT, 32'(n << 3));
         cyc(1);
         chk(32'(trace_addr_mask), 32'((1 << n) - 1));
      end
      apb(1'b1, ecs_pkg::REG_INIT, 32'h2);
      cyc(1);
      chk(32'(emu_ram_mapped), 32'h1);
   endtask
   task t_pages;
      apb(1'b1, ecs_pkg::REG_INIT, 32'h0);
      apb(1'b1, ecs_pkg::REG_MAP, 32'h1234);
      apb(1'b1, ecs_pkg::REG_INIT, 32'h4);
      cyc(1);
      chk(32'(expansion_page_b), 32'h1);
      apb(1'b1, ecs_pkg::REG_MAP, 32'habcd);
      rdc(ecs_pkg::REG_MAP, 32'habcd);
      apb(1'b1, ecs_pkg::REG_INIT, 32'h0);
      rdc(ecs_pkg::REG_MAP, 32'h1234);
      chk(32'(expansion_memory_map), 32'h1234);
   endtask
   task t_wait;
      apb(1'b1, ecs_pkg::REG_INIT, 32'h1);
      cyc(2);
      chk(32'(clk_sel_target), 32'h1);
      chk(32'(auto_first_wait_state), 32'h1);
      ecs_partner_inst.set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(2);
      ecs_partner_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(8);
      chk(32'(auto_first_wait_state), 32'h0);
      ecs_partner_inst.set_pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      cyc(8);
      chk(32'(auto_first_wait_state), 32'h1);
   endtask
   task t_panel;
      @(posedge pclk);
      front_panel_reset_n <= 1'b0;
      cyc(8);
      chk(32'(clk_sel_target), 32'h0);
      @(posedge pclk);
      front_panel_reset_n <= 1'b1;
      ecs_partner_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(6);
      rdc(ecs_pkg::REG_INIT, 32'h0);
   endtask
   task t_sync;
      apb(1'b1, ecs_pkg::REG_MODE, 32'h4);
      ecs_partner_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(6);
      chk(32'(sync_line_oe_n), 32'h0);
      apb(1'b1, ecs_pkg::REG_CMD, 32'h1);
      cyc(12);
      chk(32'(run_enable), 32'h0);
      ecs_partner_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(12);
      chk(32'(run_enable), 32'h1);
      apb(1'b1, ecs_pkg::REG_CMD, 32'h2);
      cyc(3);
      chk(32'(run_enable), 32'h0);
   endtask
   task t_poll;
      logic nxt_em;
      int   n;
      nxt_em = 1'b0;
      n = 0;
      apb(1'b1, ecs_pkg::REG_MODE, 32'h8);
      repeat (40) begin
         @(posedge pclk);
         if (poll_keyboard === 1'b1 || poll_emulator === 1'b1) begin
            chk(32'({poll_keyboard, poll_emulator}), nxt_em ? 32'h1 : 32'h2);
            nxt_em = ~nxt_em;
            n++;
         end
      end
      chk(32'(n >= 8), 32'h1);
      apb(1'b1, ecs_pkg::REG_CMD, 32'h1);
      cyc(4);
      chk(32'(run_enable), 32'h1);
      ecs_partner_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      cyc(20);
      chk(32'(run_enable), 32'h0);
      ecs_partner_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
   endtask

   // =====================================================
   // main sequence and watchdog
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_defaults;
      t_roles;
      t_init;
      t_pages;
      t_wait;
      t_panel;
      t_sync;
      t_poll;
      give_verdict;
   end
   initial begin
      #500000;
      miscompares++;
      give_verdict;
   end
endmodule
